// ---- mstep_pkg.sv ----
// Shared constants and types for the microstep position counter.
package mstep_pkg;

  // ****************************************
  // Widths
  // ****************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CNT_W = 10;

  // ****************************************
  // Register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_VS_OFFSET = 8'h04;
  localparam logic [7:0] OFS_VS_GRADIENT = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CTRL_SRC_BIT = 0;
  localparam int CTRL_RES_LSB = 4;
  localparam int STAT_EN_BIT = 16;
  localparam int STAT_ACT_BIT = 17;
  localparam int STAT_FULL_BIT = 18;

  // ****************************************
  // Reset values and codes
  // ****************************************
  localparam logic [9:0] COUNT_RESET = 10'h000;
  localparam logic [3:0] SHIFT_FULL = 4'h8;
  localparam logic [9:0] FULL_PHASE = 10'h080;
  localparam logic [3:0] SHIFT_PIN_8 = 4'h5;
  localparam logic [3:0] SHIFT_PIN_32 = 4'h3;
  localparam logic [3:0] SHIFT_PIN_64 = 4'h2;
  localparam logic [3:0] SHIFT_PIN_16 = 4'h4;

  // Configuration registers that software writes.
  typedef struct packed {
    logic res_from_reg;
    logic [3:0] res_shift;
    logic [7:0] vs_offset;
    logic [7:0] vs_gradient;
  } cfg_t;

  localparam cfg_t CFG_RESET = '{1'b0, 4'h0, 8'h00, 8'h00};

  // One register bus request.
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  // Supply states, one-hot.
  typedef enum logic [1:0] {
    ST_STANDBY = 2'b01,
    ST_ACTIVE = 2'b10
  } pwr_state_t;

endpackage

// ---- microstep_position_counter.sv ----
// Microstep position counter with standby handling and register port.
//
// Our own choices: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Power-up clears every register but the supply state, the count included, to zero.
// - Leaving standby returns configuration to its defaults.
// - Each step moves the count by 256 over the resolution.
// - Direction low counts up, so ten steps at 1/32 reach 80.
// - Fullstep positions are counts 128, 384, 640 and 896.
// - A fullstep recurs every m steps, first after m/2 steps.
// - Coarse resolutions align the count, fullstep on the 128 grid.
// - With enable high from power-up the coils hold the reset count.
// - Stopping at a multiple of 4m gives the power-up count again.
module microstep_position_counter
  import mstep_pkg::*;
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic reset_i,
  // Motion pins from the host.
  input wire logic step_i,
  input wire logic dir_i,
  input wire logic enable_i,
  input wire logic [1:0] ms_select_i,
  // High while the I/O supply is present.
  input wire logic io_supply_standby_pin_i,
  // Register port.
  input wire reg_req_t reg_req_i,
  output logic [31:0] rdata_o,
  // Drive state.
  output logic [9:0] microstep_position_count_o,
  output logic coil_energized_o,
  output logic fullstep_o,
  output logic [7:0] velocity_scaling_offset_o,
  output logic [7:0] velocity_scaling_gradient_o
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  localparam int NPIN = 6;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_meta;
  logic [NPIN-1:0] pin_sync;

  assign pin_raw = {io_supply_standby_pin_i, ms_select_i,
                    enable_i, dir_i, step_i};

  // Two flops per pin; only the second one is read by logic.
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_sync
      always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
          pin_meta[gi] <= 1'b0;
          pin_sync[gi] <= 1'b0;
        end else begin
          pin_meta[gi] <= pin_raw[gi];
          pin_sync[gi] <= pin_meta[gi];
        end
      end
    end
  endgenerate

  logic step_s;
  logic dir_s;
  logic en_s;
  logic [1:0] ms_s;
  logic supply_s;

  assign step_s = pin_sync[0];
  assign dir_s = pin_sync[1];
  assign en_s = pin_sync[2];
  assign ms_s = pin_sync[4:3];
  assign supply_s = pin_sync[5];

  // ****************************************
  // Supply state
  // ****************************************
  pwr_state_t state;
  pwr_state_t next_state;
  logic active;

  // Standby holds the count, configuration and coil drive at their defaults, so the exit
  // from standby looks exactly like a fresh power-up.
  always_comb begin
    unique case (state)
      ST_STANDBY: begin
        next_state = supply_s ? ST_ACTIVE : ST_STANDBY;
      end
      ST_ACTIVE: begin
        next_state = supply_s ? ST_ACTIVE : ST_STANDBY;
      end
      default: begin
        next_state = ST_STANDBY;
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state <= ST_STANDBY;
    end else begin
      state <= next_state;
    end
  end

  assign active = (state == ST_ACTIVE);

  // ****************************************
  // Resolution
  // ****************************************
  cfg_t cfg;
  cfg_t next_cfg;
  logic [3:0] shift;
  logic [9:0] inc;
  logic [9:0] ofs;

  // The pin straps pick the resolution unless software overrides.
  always_comb begin
    if (cfg.res_from_reg) begin
      shift = (cfg.res_shift > SHIFT_FULL) ? SHIFT_FULL
                                           : cfg.res_shift;
    end else begin
      unique case (ms_s)
        2'b00: shift = SHIFT_PIN_8;
        2'b01: shift = SHIFT_PIN_32;
        2'b10: shift = SHIFT_PIN_64;
        2'b11: shift = SHIFT_PIN_16;
      endcase
    end
  end

  assign inc = 10'h001 << shift;
  assign ofs = (shift == SHIFT_FULL) ? FULL_PHASE : 10'h000;

  // ****************************************
  // Position counter
  // ****************************************
  logic step_q;
  logic step_edge;
  logic [9:0] count;
  logic [9:0] next_count;
  logic [9:0] rel;
  logic [9:0] mask;

  assign step_edge = step_s & ~step_q;
  assign mask = ~(inc - 10'h001);
  assign rel = count - ofs;

  // Aligning to the grid before moving keeps a change of
  // resolution from leaving the count between fullsteps;
  // steps are taken with enable low so a restore can run first.
  always_comb begin
    next_count = count;
    if (!active) begin
      next_count = COUNT_RESET;
    end else if (step_edge && !dir_s) begin
      next_count = (rel & mask) + inc + ofs;
    end else if (step_edge) begin
      next_count = ((rel + inc - 10'h001) & mask) - inc + ofs;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      count <= COUNT_RESET;
      step_q <= 1'b0;
    end else begin
      count <= next_count;
      step_q <= step_s;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  logic [31:0] next_rdata;
  logic [31:0] status;
  logic energized;
  logic next_energized;

  // Status fields sit at their named positions; the rest read zero.
  always_comb begin
    status = 32'h0000_0000;
    status[CNT_W-1:0] = count;
    status[STAT_EN_BIT] = en_s;
    status[STAT_ACT_BIT] = active;
    status[STAT_FULL_BIT] = fullstep_o;
  end

  // Writes steer configuration; standby forces defaults.
  always_comb begin
    next_cfg = cfg;
    if (!active) begin
      next_cfg = CFG_RESET;
    end else if (reg_req_i.wr) begin
      unique case (reg_req_i.addr)
        OFS_CONTROL: begin
          next_cfg.res_from_reg = reg_req_i.wdata[CTRL_SRC_BIT];
          next_cfg.res_shift =
            reg_req_i.wdata[CTRL_RES_LSB +: 4];
        end
        OFS_VS_OFFSET: next_cfg.vs_offset = reg_req_i.wdata[7:0];
        OFS_VS_GRADIENT: next_cfg.vs_gradient = reg_req_i.wdata[7:0];
        default: next_cfg = cfg;
      endcase
    end
  end

  // Reads answer in the next cycle only; unmapped reads give zero.
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (reg_req_i.rd) begin
      unique case (reg_req_i.addr)
        OFS_CONTROL: begin
          next_rdata[CTRL_SRC_BIT] = cfg.res_from_reg;
          next_rdata[CTRL_RES_LSB +: 4] = cfg.res_shift;
        end
        OFS_VS_OFFSET: next_rdata[7:0] = cfg.vs_offset;
        OFS_VS_GRADIENT: next_rdata[7:0] = cfg.vs_gradient;
        OFS_STATUS: next_rdata = status;
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end

  assign next_energized = active & en_s;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      cfg <= CFG_RESET;
      rdata_o <= 32'h0000_0000;
      energized <= 1'b0;
    end else begin
      cfg <= next_cfg;
      rdata_o <= next_rdata;
      energized <= next_energized;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign microstep_position_count_o = count;
  assign coil_energized_o = energized;
  assign fullstep_o = (count[7:0] == FULL_PHASE[7:0]);
  assign velocity_scaling_offset_o = cfg.vs_offset;
  assign velocity_scaling_gradient_o = cfg.vs_gradient;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  standby_clear_a: assert property (
    !active |=> count == COUNT_RESET
  ) else $error("count not cleared in standby");

  cfg_default_a: assert property (
    !active |=> cfg == CFG_RESET
  ) else $error("config not at defaults after standby");

  step_up_a: assert property (
    active && step_edge && !dir_s && shift != SHIFT_FULL
    && (count & ~mask) == 10'h000
    |=> count == $past(count) + $past(inc)
  ) else $error("wrong upward step size");

  step_down_a: assert property (
    active && step_edge && dir_s && shift != SHIFT_FULL
    && (count & ~mask) == 10'h000
    |=> count == $past(count) - $past(inc)
  ) else $error("wrong downward step size");

  count_hold_a: assert property (
    active && !step_edge |=> $stable(count)
  ) else $error("count moved without a step");

  fullstep_grid_a: assert property (
    active && step_edge && shift == SHIFT_FULL
    |=> count[7:0] == 8'h80
  ) else $error("fullstep mode left the fullstep grid");

  fullstep_val_a: assert property (
    fullstep_o |-> count inside {10'd128, 10'd384,
                                 10'd640, 10'd896}
  ) else $error("fullstep flag at a wrong count");

  energize_a: assert property (
    active && $rose(en_s) |=> coil_energized_o ##0 count == $past(count)
      || $past(step_edge)
  ) else $error("coils not energized after enable");

  status_read_a: assert property (
    reg_req_i.rd && reg_req_i.addr == OFS_STATUS
    |=> rdata_o[9:0] == $past(count)
  ) else $error("status read does not show the count");

endmodule
`default_nettype wire

// ---- host_model.sv ----
// Host controller model driving the motion and supply pins of the driver.
`timescale 1ns/1ps
`default_nettype none

module host_model (
  // Clock.
  input wire logic clk_i,
  // Pins toward the driver.
  output logic step_o,
  output logic dir_o,
  output logic enable_o,
  output logic supply_o
);
  // Step count that the host tracks since the first power-up.
  int position;

  // ****************************************
  // Pin sequences
  // ****************************************
  // Pins idle low with the supply on, so the coils start switched off.
  initial begin
    step_o = 1'b0;
    dir_o = 1'b0;
    enable_o = 1'b0;
    supply_o = 1'b1;
    position = 0;
  end

  // Direction settles 3 clocks before the first edge, and each step
  // level lasts 3 clocks, since shorter pulses could be lost.
  task automatic steps(input int n, input logic dir);
    @(posedge clk_i);
    dir_o <= dir;
    repeat (3) @(posedge clk_i);
    for (int i = 0; i < n; i++) begin
      step_o <= 1'b1;
      repeat (3) @(posedge clk_i);
      step_o <= 1'b0;
      repeat (3) @(posedge clk_i);
    end
    position = dir ? position - n : position + n;
    repeat (2) @(posedge clk_i);
    #1;
  endtask

  // Enable changes, then the synchroniser is given time to follow.
  task automatic set_enable(input logic en);
    @(posedge clk_i);
    enable_o <= en;
    repeat (5) @(posedge clk_i);
    #1;
  endtask

  // The motor is at rest here; every input goes low before the supply,
  // otherwise the input clamps would hold the supply pin up.
  task automatic standby();
    @(posedge clk_i);
    step_o <= 1'b0;
    dir_o <= 1'b0;
    enable_o <= 1'b0;
    repeat (4) @(posedge clk_i);
    supply_o <= 1'b0;
    repeat (6) @(posedge clk_i);
    supply_o <= 1'b1;
    repeat (5) @(posedge clk_i);
    #1;
  endtask
endmodule

`default_nettype wire

// ---- tb_top.sv ----
// Self-checking testbench for the microstep position counter.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import mstep_pkg::*;

  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [1:0] ms_select_i = 2'b01;
  reg_req_t reg_req_i = '0;
  wire logic step, dir, enable, supply;
  logic [31:0] rdata;
  logic [9:0] count;
  logic coil, full;
  logic [7:0] velocity_scaling_offset, velocity_scaling_gradient;
  int fail_count = 0;
  int checked = 0;

  // Free-running 125 MHz clock.
  always #4 clk_i = ~clk_i;

  microstep_position_counter DUT (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .step_i(step),
    .dir_i(dir),
    .enable_i(enable),
    .ms_select_i(ms_select_i),
    .io_supply_standby_pin_i(supply),
    .reg_req_i(reg_req_i),
    .rdata_o(rdata),
    .microstep_position_count_o(count),
    .coil_energized_o(coil),
    .fullstep_o(full),
    .velocity_scaling_offset_o(velocity_scaling_offset),
    .velocity_scaling_gradient_o(velocity_scaling_gradient)
  );

  host_model host (
    .clk_i(clk_i),
    .step_o(step),
    .dir_o(dir),
    .enable_o(enable),
    .supply_o(supply)
  );

  // ****************************************
  // Helpers
  // ****************************************
  // Case equality keeps an unknown from passing as a match.
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cnt_check(input logic [9:0] exp);
    check({22'h0, count}, {22'h0, exp});
  endtask

  // One-cycle write strobe; the register updates at the strobe's edge.
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_req_i <= '{a, d, 1'b1, 1'b0};
    @(posedge clk_i);
    reg_req_i <= '0;
    #1;
  endtask

  // Read data stand only in the cycle after the strobe.
  task automatic rd_check(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_i);
    reg_req_i <= '{a, 32'h00000000, 1'b0, 1'b1};
    @(posedge clk_i);
    reg_req_i <= '0;
    #1 check(rdata, exp);
  endtask

  task automatic finish_test();
    $display("checks %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ****************************************
  // Tests
  // ****************************************
  // Main sequence; each host pin task waits out the pin synchronisers.
  initial begin
    repeat (12) @(posedge clk_i);
    reset_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    #1;
    cnt_check(10'h000);
    rd_check(OFS_STATUS, 32'h00020000);
    reg_write(OFS_VS_OFFSET, 32'h0000005A);
    reg_write(OFS_VS_GRADIENT, 32'h000000C3);
    check({24'h000000, velocity_scaling_offset}, 32'h0000005A);
    check({24'h000000, velocity_scaling_gradient}, 32'h000000C3);
    rd_check(OFS_VS_GRADIENT, 32'h000000C3);
    rd_check(8'h10, 32'h00000000);
    check({31'h0, coil}, 32'h00000000);
    host.set_enable(1'b1);
    check({31'h0, coil}, 32'h00000001);
    cnt_check(10'h000);
    host.steps(10, 1'b0);
    cnt_check(10'h050);
    host.steps(6, 1'b0);
    cnt_check(10'h080);
    check({31'h0, full}, 32'h00000001);
    host.steps(17, 1'b1);
    cnt_check(10'h3F8);
    // The resolution straps go low with the other inputs.
    @(posedge clk_i);
    ms_select_i <= 2'b00;
    host.standby();
    cnt_check(10'h000);
    check({24'h000000, velocity_scaling_offset}, 32'h00000000);
    check({24'h000000, velocity_scaling_gradient}, 32'h00000000);
    rd_check(OFS_VS_GRADIENT, 32'h00000000);
    // Restore at 1/32 from the tracked position, enable still low.
    @(posedge clk_i);
    ms_select_i <= 2'b01;
    host.steps(((host.position % 128) + 128) % 128, 1'b0);
    cnt_check(10'h3F8);
    @(posedge clk_i);
    ms_select_i <= 2'b00;
    host.standby();
    cnt_check(10'h000);
    host.steps(4, 1'b0);
    cnt_check(10'h080);
    host.steps(28, 1'b0);
    cnt_check(10'h000);
    reg_write(OFS_CONTROL, 32'h00000081);
    host.steps(1, 1'b0);
    cnt_check(10'h080);
    host.steps(1, 1'b0);
    cnt_check(10'h180);
    reg_write(OFS_CONTROL, 32'h00000001);
    host.steps(3, 1'b0);
    cnt_check(10'h183);
    finish_test();
  end

  // Watchdog: the sequence needs well under 2000 clocks.
  initial begin
    #200000;
    fail_count++;
    finish_test();
  end
endmodule

`default_nettype wire
